// ===== fpci_params.svh
// Constants of the flash protection command interface
`ifndef FPCI_PARAMS_SVH
`define FPCI_PARAMS_SVH
`define FPCI_ADDR_W 24
`define FPCI_DATA_W 16
`define FPCI_CA_W 14
`define FPCI_CA_1554 14'h1554
`define FPCI_CA_2AA8 14'h2aa8
`define FPCI_CA_2A54 14'h2a54
`define FPCI_CA_15A8 14'h15a8
`define FPCI_CD_ENA1 8'ha8
`define FPCI_CD_ENA2 8'h54
`define FPCI_CD_RESET 8'hf0
`define FPCI_CD_PROG 8'ha0
`define FPCI_CD_ERASE 8'h80
`define FPCI_CD_BLK_CONF 8'h30
`define FPCI_CD_CHIP 8'h10
`define FPCI_CD_SUSPEND 8'hb0
`define FPCI_CD_RESUME 8'h30
`define FPCI_CD_READ_PROT 8'h90
`define FPCI_CD_SET_PROT 8'hc0
`define FPCI_CD_BLK_UNLOCK 8'hc1
`define FPCI_WD_SET_CODE 16'h7fff
`define FPCI_WD_CODE_UNLOCK 16'h0fff
`define FPCI_WD_CODE_RELOCK 16'hfffb
`define FPCI_TRAP_OPCODE 16'h009b
`define FPCI_PR_RESET 16'hffff
`define FPCI_PR_LOCKED 16'h0000
`define FPCI_PR_CODE_BIT 15
`define FPCI_PR_BLK_N 7
`define FPCI_ODD_WORD 2'b10
`endif

// ===== fpci_pkg.sv
// Types of the flash protection command interface
package fpci_pkg;
  typedef logic [23:0] fpci_addr_t;
  typedef logic [15:0] fpci_data_t;
  typedef enum logic [3:0] {
    FPCI_S_READ, FPCI_S_A1, FPCI_S_A2, FPCI_S_PW, FPCI_S_E3, FPCI_S_E4, FPCI_S_E5,
    FPCI_S_P1, FPCI_S_P2, FPCI_S_SP, FPCI_S_RP, FPCI_S_BTU
  } fpci_state_t;
  typedef struct packed {
    fpci_state_t st;
    logic pr_loaded;
    fpci_data_t act_pr;
    logic blk_unlock;
    logic code_unlock;
    fpci_data_t rd_data;
    fpci_addr_t op_addr;
    fpci_data_t op_data;
    logic prog_req;
    logic blk_erase_req;
    logic chip_erase_req;
    logic suspend_req;
    logic resume_req;
  } fpci_main_t;
  typedef struct packed {
    fpci_data_t nv_pr;
    logic err;
  } fpci_store_t;
endpackage

// ===== fpci_prot_if.sv
// Carrier between command decoder and protection store
`timescale 1ns/1ns
`default_nettype none
interface fpci_prot_if;
  logic wr;
  logic [15:0] wdata;
  logic [15:0] nv_pr;
  logic err;
  modport cmd (output wr, output wdata, input nv_pr, input err);
  modport store (input wr, input wdata, output nv_pr, output err);
endinterface
`default_nettype wire

// ===== fpci_prot_store.sv
// Non-volatile protection register: bits may only be cleared
`timescale 1ns/1ns
`default_nettype none
`include "fpci_params.svh"
module fpci_prot_store (
  input wire logic clk_sys, // System clock
  input wire logic por_rst, // Power-on reset, async, high
  input wire logic ce, // Clock enable
  fpci_prot_if.store pf // Write port and stored value
);
  import fpci_pkg::*;
  fpci_store_t r;
  fpci_store_t next_r;

  always_comb begin
    next_r = r;
    next_r.err = 1'b0;
    if (pf.wr) begin
      next_r.nv_pr = r.nv_pr & pf.wdata;
      next_r.err = |(pf.wdata & ~r.nv_pr);
    end
  end

  always_ff @(posedge clk_sys or posedge por_rst) begin
    if (por_rst) begin
      r <= '{nv_pr: `FPCI_PR_RESET, err: 1'b0};
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign pf.nv_pr = r.nv_pr;
  assign pf.err = r.err;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (por_rst);

  property p_no_set;
    ce && pf.wr |=> (r.nv_pr & ~$past(r.nv_pr)) == 16'h0000;
  endproperty
  a_no_set: assert property (p_no_set) else $error("cleared bit came back");

  property p_wr_err;
    ce && pf.wr && |(pf.wdata & ~r.nv_pr) |=> r.err;
  endproperty
  a_wr_err: assert property (p_wr_err) else $error("write error not flagged");
endmodule
`default_nettype wire

// ===== fpci_top.sv
// Flash command interface: command decode and protection
// Operation
// - New protection value acts only after reset
// - Zero bits must stay zero on write
// - Status command makes odd words read protection
// - Prefix, C1, F0 lifts all block protection
// - Reset cancels temporary block unprotection
// - Locked code read from outside returns trap
// - Prefix then 7FFF at odd word locks code
// - No command ever clears stored code lock
// - 0FFF from flash fetch unlocks code temporarily
// - System reset ends temporary code unlock
// - FFFB from flash fetch relocks code
// - F0 returns reads to array data
// - B0 at any address suspends erase
// - Prefix, A0 at 1554, then address/data
// - Prefix, 80, prefix, 30 erases block
// - Prefix, 80, prefix, 10 erases chip
// - Command addresses ignore bit 14 upward
`timescale 1ns/1ns
`default_nettype none
`include "fpci_params.svh"
module fpci_top (
  input wire logic clk_sys, // System clock, 25 MHz
  input wire logic sys_rst, // System reset, async, high
  input wire logic por_rst, // Power-on reset of stored protection
  input wire logic ce, // Clock enable, freezes all state
  input wire logic wr_en, // CPU write cycle to flash
  input wire logic rd_en, // CPU read cycle from flash
  input wire fpci_pkg::fpci_addr_t addr, // CPU byte address
  input wire fpci_pkg::fpci_data_t wdata, // CPU write data
  input wire logic fetch_flash, // Current instruction fetched from flash
  input wire fpci_pkg::fpci_data_t arr_data, // Array word at addr
  output logic [15:0] rd_data, // Read answer, one cycle later
  output logic [23:0] op_addr, // Address for program or erase
  output logic [15:0] op_data, // Word to program
  output logic prog_req, // Program word pulse
  output logic blk_erase_req, // Block erase pulse
  output logic chip_erase_req, // Chip erase pulse
  output logic suspend_req, // Erase suspend pulse
  output logic resume_req, // Erase resume pulse
  output logic [6:0] blk_unprot, // High: block may be changed
  output logic code_locked, // Code protection in force
  output logic prot_wr_err // Protection write error pulse
);
  import fpci_pkg::*;

  fpci_prot_if pf ();
  fpci_main_t r;
  fpci_main_t next_r;
  logic wr_go;
  logic rd_go;
  logic odd_word;

  fpci_prot_store u_store (
    .clk_sys(clk_sys),
    .por_rst(por_rst),
    .ce(ce),
    .pf(pf)
  );

  // Coded cycle match: low data byte and low address bits only
  function automatic logic hit(input fpci_addr_t a, input fpci_data_t d,
                               input logic [7:0] code, input logic [13:0] ca);
    return (d[7:0] == code) && (a[13:0] == ca);
  endfunction

  assign wr_go = wr_en & ce;
  assign rd_go = rd_en & ce;
  assign odd_word = (addr[1:0] == `FPCI_ODD_WORD);
  assign code_locked = ~r.act_pr[`FPCI_PR_CODE_BIT] & ~r.code_unlock;

  always_comb begin
    next_r = r;
    next_r.prog_req = 1'b0;
    next_r.blk_erase_req = 1'b0;
    next_r.chip_erase_req = 1'b0;
    next_r.suspend_req = 1'b0;
    next_r.resume_req = 1'b0;
    pf.wr = 1'b0;
    pf.wdata = wdata;
    // Active copy taken from the store once, after reset only
    if (!r.pr_loaded) begin
      next_r.act_pr = pf.nv_pr;
      next_r.pr_loaded = 1'b1;
    end
    if (rd_go) begin
      if (r.st == FPCI_S_RP && odd_word) begin
        next_r.rd_data = r.act_pr;
      end else if (code_locked && !fetch_flash) begin
        next_r.rd_data = `FPCI_TRAP_OPCODE;
      end else begin
        next_r.rd_data = arr_data;
      end
    end
    if (wr_go) begin
      next_r.st = FPCI_S_READ;
      unique case (r.st)
        FPCI_S_READ, FPCI_S_RP: begin
          if (hit(addr, wdata, `FPCI_CD_ENA1, `FPCI_CA_1554)) begin
            next_r.st = FPCI_S_A1;
          end else if (hit(addr, wdata, `FPCI_CD_ENA1, `FPCI_CA_2A54)) begin
            next_r.st = FPCI_S_P1;
          end else if (wdata[7:0] == `FPCI_CD_SUSPEND) begin
            next_r.suspend_req = 1'b1;
          end else if (wdata[7:0] == `FPCI_CD_RESUME) begin
            next_r.resume_req = 1'b1;
          end
          if (fetch_flash && wdata == `FPCI_WD_CODE_UNLOCK) begin
            next_r.code_unlock = 1'b1;
          end
          if (fetch_flash && wdata == `FPCI_WD_CODE_RELOCK) begin
            next_r.code_unlock = 1'b0;
          end
        end
        FPCI_S_A1: begin
          if (hit(addr, wdata, `FPCI_CD_ENA2, `FPCI_CA_2AA8)) begin
            next_r.st = FPCI_S_A2;
          end
        end
        FPCI_S_A2: begin
          if (hit(addr, wdata, `FPCI_CD_PROG, `FPCI_CA_1554)) begin
            next_r.st = FPCI_S_PW;
          end else if (hit(addr, wdata, `FPCI_CD_ERASE, `FPCI_CA_1554)) begin
            next_r.st = FPCI_S_E3;
          end
        end
        FPCI_S_PW: begin
          next_r.prog_req = 1'b1;
          next_r.op_addr = addr;
          next_r.op_data = wdata;
        end
        FPCI_S_E3: begin
          if (hit(addr, wdata, `FPCI_CD_ENA1, `FPCI_CA_1554)) begin
            next_r.st = FPCI_S_E4;
          end
        end
        FPCI_S_E4: begin
          if (hit(addr, wdata, `FPCI_CD_ENA2, `FPCI_CA_2AA8)) begin
            next_r.st = FPCI_S_E5;
          end
        end
        FPCI_S_E5: begin
          if (hit(addr, wdata, `FPCI_CD_CHIP, `FPCI_CA_1554)) begin
            next_r.chip_erase_req = 1'b1;
          end else if (wdata[7:0] == `FPCI_CD_BLK_CONF) begin
            next_r.blk_erase_req = 1'b1;
            next_r.op_addr = addr;
          end
        end
        FPCI_S_P1: begin
          if (hit(addr, wdata, `FPCI_CD_ENA2, `FPCI_CA_15A8)) begin
            next_r.st = FPCI_S_P2;
          end
        end
        FPCI_S_P2: begin
          if (hit(addr, wdata, `FPCI_CD_READ_PROT, `FPCI_CA_2A54)) begin
            next_r.st = FPCI_S_RP;
          end else if (hit(addr, wdata, `FPCI_CD_SET_PROT, `FPCI_CA_2A54)) begin
            next_r.st = FPCI_S_SP;
          end else if (hit(addr, wdata, `FPCI_CD_BLK_UNLOCK, `FPCI_CA_2A54)) begin
            next_r.st = FPCI_S_BTU;
          end else if (odd_word && wdata == `FPCI_WD_SET_CODE) begin
            pf.wr = 1'b1;
          end
        end
        FPCI_S_SP: begin
          pf.wr = 1'b1;
        end
        FPCI_S_BTU: begin
          if (wdata[7:0] == `FPCI_CD_RESET) begin
            next_r.blk_unlock = 1'b1;
          end
        end
      endcase
    end
  end

  // Reset drops both temporary unlocks and loads a locked active copy
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '{st: FPCI_S_READ, pr_loaded: 1'b0, act_pr: `FPCI_PR_LOCKED,
             blk_unlock: 1'b0, code_unlock: 1'b0, default: '0};
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign rd_data = r.rd_data;
  assign op_addr = r.op_addr;
  assign op_data = r.op_data;
  assign prog_req = r.prog_req;
  assign blk_erase_req = r.blk_erase_req;
  assign chip_erase_req = r.chip_erase_req;
  assign suspend_req = r.suspend_req;
  assign resume_req = r.resume_req;
  assign blk_unprot = r.act_pr[`FPCI_PR_BLK_N-1:0] | {`FPCI_PR_BLK_N{r.blk_unlock}};
  assign prot_wr_err = pf.err;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_rd_status;
    rd_go && r.st == FPCI_S_RP && odd_word;
  endsequence
  sequence s_rd_trap;
    rd_go && !(r.st == FPCI_S_RP && odd_word) && code_locked && !fetch_flash;
  endsequence
  sequence s_blk_unlock;
    wr_go && r.st == FPCI_S_BTU && wdata[7:0] == `FPCI_CD_RESET;
  endsequence
  sequence s_pw_data;
    wr_go && r.st == FPCI_S_PW;
  endsequence

  property p_act_pr_held;
    r.pr_loaded |=> r.act_pr == $past(r.act_pr);
  endproperty
  a_act_pr_held: assert property (p_act_pr_held) else $error("active PR changed");

  property p_status;
    s_rd_status |=> rd_data == $past(r.act_pr);
  endproperty
  a_status: assert property (p_status) else $error("status read wrong");

  property p_trap;
    s_rd_trap |=> rd_data == `FPCI_TRAP_OPCODE;
  endproperty
  a_trap: assert property (p_trap) else $error("trap opcode missing");

  property p_blk_unlock;
    s_blk_unlock |=> blk_unprot == 7'h7f && r.st == FPCI_S_READ;
  endproperty
  a_blk_unlock: assert property (p_blk_unlock) else $error("blocks not unlocked");

  property p_code_unlock;
    $rose(r.code_unlock) |-> $past(wr_go && fetch_flash && wdata == `FPCI_WD_CODE_UNLOCK);
  endproperty
  a_code_unlock: assert property (p_code_unlock) else $error("unlock without cause");

  property p_code_relock;
    $fell(r.code_unlock) |-> $past(wr_go && fetch_flash && wdata == `FPCI_WD_CODE_RELOCK);
  endproperty
  a_code_relock: assert property (p_code_relock) else $error("relock without cause");

  property p_program;
    s_pw_data |=> prog_req && op_addr == $past(addr) ##1 !prog_req;
  endproperty
  a_program: assert property (p_program) else $error("program pulse wrong");

  property p_abort;
    wr_go && r.st == FPCI_S_A1 && !hit(addr, wdata, `FPCI_CD_ENA2, `FPCI_CA_2AA8)
      |=> r.st == FPCI_S_READ;
  endproperty
  a_abort: assert property (p_abort) else $error("bad cycle not aborted");

  property p_suspend;
    wr_go && r.st == FPCI_S_READ && wdata[7:0] == `FPCI_CD_SUSPEND |=> suspend_req;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend missing");

  property p_chip;
    wr_go && r.st == FPCI_S_E5 && hit(addr, wdata, `FPCI_CD_CHIP, `FPCI_CA_1554)
      |=> chip_erase_req;
  endproperty
  a_chip: assert property (p_chip) else $error("chip erase missing");
endmodule
`default_nettype wire

// ===== fpci_cpu_model.sv
// CPU core model issuing flash bus cycles
`timescale 1ns/1ns
`default_nettype none
module fpci_cpu_model (
  input wire logic clk_sys, // System clock
  output var logic wr_en, // Write cycle
  output var logic rd_en, // Read cycle
  output var logic [23:0] addr, // Byte address
  output var logic [15:0] wdata, // Write data
  output var logic fetch_flash, // Caller runs from flash
  output logic [15:0] arr_data // Array word at addr
);
  // Array word outside reads is scrambled
  assign arr_data = rd_en ? (addr[16:1] ^ 16'h3c3c) : ~(addr[16:1] ^ 16'h3c3c);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 24'h000000;
    wdata = 16'h0000;
    fetch_flash = 1'b0;
  end
  task automatic wr(input logic [23:0] a, input logic [15:0] d, input logic ff);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    fetch_flash <= ff;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    wdata <= ~d;
  endtask
  task automatic rd(input logic [23:0] a, input logic ff);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    fetch_flash <= ff;
    @(posedge clk_sys);
    rd_en <= 1'b0;
  endtask
  task automatic prot_prefix();
    wr(24'h002a54, 16'h00a8, 1'b0);
    wr(24'h0015a8, 16'h0054, 1'b0);
  endtask
  task automatic ci_prefix(input logic [23:0] hi);
    wr(hi | 24'h001554, 16'h00a8, 1'b0);
    wr(hi | 24'h002aa8, 16'h0054, 1'b0);
  endtask
  task automatic set_prot(input logic [15:0] wpr);
    prot_prefix();
    wr(24'h002a54, 16'h00c0, 1'b0);
    wr(24'h000006, wpr, 1'b0);
  endtask
  task automatic leave_status();
    wr(24'h000000, 16'h00f0, 1'b0);
  endtask
endmodule
`default_nettype wire

// ===== test_flash_protection_command_interface.sv
// Self-checking bench of the flash protection command interface
`timescale 1ns/1ns
`default_nettype none
module test_flash_protection_command_interface;
  logic clk_sys, sys_rst, por_rst, ce, wr_en, rd_en, fetch_flash;
  logic [23:0] addr, op_addr;
  logic [15:0] wdata, arr_data, rd_data, op_data;
  logic prog_req, blk_erase_req, chip_erase_req, suspend_req, resume_req;
  logic code_locked, prot_wr_err;
  logic [6:0] blk_unprot;
  logic [4:0] pv;
  int pc [5];
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  fpci_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .por_rst(por_rst), .ce(ce),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .fetch_flash(fetch_flash),
    .arr_data(arr_data), .rd_data(rd_data), .op_addr(op_addr), .op_data(op_data),
    .prog_req(prog_req), .blk_erase_req(blk_erase_req), .chip_erase_req(chip_erase_req),
    .suspend_req(suspend_req), .resume_req(resume_req), .blk_unprot(blk_unprot),
    .code_locked(code_locked), .prot_wr_err(prot_wr_err));
  fpci_cpu_model cpu (.clk_sys(clk_sys), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .fetch_flash(fetch_flash), .arr_data(arr_data));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Pulse counters per request output
  assign pv = {resume_req, suspend_req, chip_erase_req, blk_erase_req, prog_req};
  always @(posedge clk_sys) begin
    for (int i = 0; i < 5; i++) begin
      if (pv[i] === 1'b1) pc[i]++;
    end
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  function automatic logic [15:0] arr(input logic [23:0] a);
    return a[16:1] ^ 16'h3c3c;
  endfunction
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic clr();
    @(negedge clk_sys);
    for (int i = 0; i < 5; i++) pc[i] = 0;
  endtask
  task automatic rd_chk(input logic [23:0] a, input logic ff, input logic [15:0] e);
    cpu.rd(a, ff);
    @(negedge clk_sys);
    chk(rd_data, e);
  endtask
  task automatic sys_reset();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic t_status();
    rd_chk(24'h000006, 1'b0, arr(24'h000006));
    chk(blk_unprot, 7'h7f);
    cpu.prot_prefix();
    cpu.wr(24'h002a54, 16'h0090, 1'b0);
    rd_chk(24'h000006, 1'b0, 16'hffff);
    rd_chk(24'h000004, 1'b0, arr(24'h000004));
    cpu.leave_status();
    rd_chk(24'h000006, 1'b0, arr(24'h000006));
  endtask
  task automatic t_program();
    clr();
    cpu.ci_prefix(24'h00c000);
    cpu.wr(24'h01d554, 16'h00a0, 1'b0);
    cpu.wr(24'h012340, 16'h1234, 1'b0);
    @(negedge clk_sys);
    chk(prog_req, 1'b1);
    chk(op_addr, 24'h012340);
    chk(op_data, 16'h1234);
    @(negedge clk_sys);
    chk(prog_req, 1'b0);
  endtask
  task automatic t_erase();
    clr();
    cpu.ci_prefix(24'h000000);
    cpu.wr(24'h001554, 16'h0080, 1'b0);
    cpu.ci_prefix(24'h000000);
    cpu.wr(24'h024000, 16'h0030, 1'b0);
    @(negedge clk_sys);
    chk(blk_erase_req, 1'b1);
    chk(op_addr, 24'h024000);
    cpu.ci_prefix(24'h000000);
    cpu.wr(24'h001554, 16'h0080, 1'b0);
    cpu.ci_prefix(24'h000000);
    cpu.wr(24'h001554, 16'h0010, 1'b0);
    @(negedge clk_sys);
    chk(chip_erase_req, 1'b1);
    // Wrong erase code, then a prefix with chip code third
    cpu.ci_prefix(24'h000000);
    cpu.wr(24'h001554, 16'h0055, 1'b0);
    cpu.ci_prefix(24'h000000);
    cpu.wr(24'h001554, 16'h0010, 1'b0);
    repeat (2) @(negedge clk_sys);
    chk(pc[2], 1);
    chk(pc[1], 1);
    chk(pc[4], 0);
  endtask
  task automatic t_suspend();
    clr();
    // Bad second enable cycle must drop back to read state
    cpu.wr(24'h001554, 16'h00a8, 1'b0);
    cpu.wr(24'h002aa8, 16'h0055, 1'b0);
    cpu.wr(24'h00abce, 16'h00b0, 1'b0);
    cpu.wr(24'h000100, 16'h0030, 1'b0);
    repeat (2) @(negedge clk_sys);
    chk(pc[3], 1);
    chk(pc[4], 1);
  endtask
  task automatic t_set_prot();
    cpu.set_prot(16'hfffe);
    @(negedge clk_sys);
    chk(prot_wr_err, 1'b0);
    chk(blk_unprot, 7'h7f);
    cpu.prot_prefix();
    cpu.wr(24'h002a54, 16'h0090, 1'b0);
    rd_chk(24'h000002, 1'b0, 16'hffff);
    cpu.leave_status();
    sys_reset();
    chk(blk_unprot, 7'h7e);
    cpu.set_prot(16'hffff);
    @(negedge clk_sys);
    chk(prot_wr_err, 1'b1);
  endtask
  task automatic t_blk_unlock();
    cpu.prot_prefix();
    cpu.wr(24'h002a54, 16'h00c1, 1'b0);
    cpu.wr(24'h000000, 16'h00f0, 1'b0);
    @(negedge clk_sys);
    chk(blk_unprot, 7'h7f);
    sys_reset();
    chk(blk_unprot, 7'h7e);
  endtask
  task automatic t_code();
    cpu.prot_prefix();
    cpu.wr(24'h000006, 16'h7fff, 1'b0);
    @(negedge clk_sys);
    chk(prot_wr_err, 1'b1);
    chk(code_locked, 1'b0);
    sys_reset();
    chk(code_locked, 1'b1);
    rd_chk(24'h000100, 1'b0, 16'h009b);
    rd_chk(24'h000100, 1'b1, arr(24'h000100));
    cpu.wr(24'h000200, 16'h0fff, 1'b0);
    rd_chk(24'h000100, 1'b0, 16'h009b);
    cpu.wr(24'h000200, 16'h0fff, 1'b1);
    rd_chk(24'h000100, 1'b0, arr(24'h000100));
    cpu.wr(24'h000200, 16'hfffb, 1'b1);
    @(negedge clk_sys);
    chk(code_locked, 1'b1);
    cpu.wr(24'h000200, 16'h0fff, 1'b1);
    sys_reset();
    chk(code_locked, 1'b1);
    cpu.set_prot(16'hffff);
    sys_reset();
    chk(code_locked, 1'b1);
  endtask
  // Cycles while clock enable is low are ignored
  task automatic t_freeze();
    clr();
    @(posedge clk_sys);
    ce <= 1'b0;
    cpu.wr(24'h000000, 16'h00b0, 1'b0);
    cpu.rd(24'h000100, 1'b1);
    repeat (2) @(negedge clk_sys);
    chk(pc[3], 0);
    chk(rd_data, arr(24'h000006));
    @(posedge clk_sys);
    ce <= 1'b1;
    cpu.wr(24'h000000, 16'h00b0, 1'b0);
    repeat (2) @(negedge clk_sys);
    chk(pc[3], 1);
  endtask
  // Power-on reset restores the stored register, seen after reset
  task automatic t_power();
    @(posedge clk_sys);
    por_rst <= 1'b1;
    sys_reset();
    @(posedge clk_sys);
    por_rst <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(code_locked, 1'b0);
    chk(blk_unprot, 7'h7f);
  endtask
  initial begin
    sys_rst = 1'b1;
    por_rst = 1'b1;
    ce = 1'b1;
    for (int i = 0; i < 5; i++) pc[i] = 0;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    t_status();
    t_program();
    t_erase();
    t_suspend();
    t_freeze();
    t_set_prot();
    t_blk_unlock();
    t_code();
    t_power();
    tally_and_finish();
  end
endmodule
`default_nettype wire
